// ==== rabsg_drv_model.sv ====
`default_nettype none
// Gate drivers and shunt: current ramps while a sensing pattern is applied
module rabsg_drv_model (
  input  wire logic                    i_ref_clk,
  input  wire rabsg_pkg::rabsg_gates_t i_gates,
  input  wire logic [2:0]              i_pol,
  output logic [11:0]                  o_cur
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] fwd;
  logic [2:0] opp;
  // Which leg sees a forward or an opposing pattern
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      fwd[k] = i_gates == (6'h15 ^ (6'h03 << 2 * k));
      opp[k] = i_gates == (6'h2A ^ (6'h03 << 2 * k));
    end
  end
  // Faster rise where the field aids the magnet; zero when undriven
  always_ff @(posedge i_ref_clk) begin
    if ((fwd & i_pol) != 3'h0 || (opp & ~i_pol) != 3'h0) o_cur <= o_cur + 12'h003;
    else if ((fwd | opp) != 3'h0) o_cur <= o_cur + 12'h002;
    else o_cur <= 12'h000;
  end
endmodule
`default_nettype wire

// ==== rabsg_leg_guard.sv ====
`default_nettype none
// Final per-leg gate stage: zero vector override and shoot-through block
module rabsg_leg_guard (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_zero_vec,
  input  wire rabsg_pkg::rabsg_leg_t  i_req,
  output logic                        o_hi,
  output logic                        o_lo
);

  logic hi_r;
  logic hi_nxt;
  logic lo_r;
  logic lo_nxt;

  // Zero vector overrides any request; both-on request resolves to off
  always_comb begin
    if (i_zero_vec) begin
      hi_nxt = 1'b0;
      lo_nxt = 1'b1;
    end else if (i_req.hi && i_req.lo) begin
      hi_nxt = 1'b0;
      lo_nxt = 1'b0;
    end else begin
      hi_nxt = i_req.hi;
      lo_nxt = i_req.lo;
    end
  end

  // Registered gate outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end else begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end

  assign o_hi = hi_r;
  assign o_lo = lo_r;

endmodule
`default_nettype wire

// ==== rabsg_pkg.sv ====
`default_nettype none
package rabsg_pkg;

  // Time each sensing pattern is applied, and its count at 40 MHz
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned PULSE_TIME_US   = 50;
  localparam int unsigned PULSE_CYC       = (PULSE_TIME_US * (CLK_HZ / 1_000_000));
  // Settling gap between patterns (all legs off)
  localparam int unsigned GAP_TIME_US     = 20;
  localparam int unsigned GAP_CYC         = (GAP_TIME_US * (CLK_HZ / 1_000_000));

  // Default feedback widths
  localparam int unsigned CUR_W           = 12;
  localparam int unsigned VBUS_W          = 12;

  // Reset value of the surge threshold
  localparam logic [11:0] SURGE_THR_RST   = 12'hC00;

  // Gate drive of one inverter leg
  typedef struct packed {
    logic hi;
    logic lo;
  } rabsg_leg_t;

  // Gate drive of all three legs
  typedef struct packed {
    rabsg_leg_t w;
    rabsg_leg_t v;
    rabsg_leg_t u;
  } rabsg_gates_t;

  // Outcome of rotor alignment
  typedef struct packed {
    logic       valid;
    logic [2:0] polarity;
    logic [2:0] sector;
  } rabsg_align_t;

endpackage
`default_nettype wire

// ==== rabsg_top.sv ====
`default_nettype none
module rabsg_top #(
  parameter int unsigned PULSE_CYC = rabsg_pkg::PULSE_CYC,
  parameter int unsigned GAP_CYC   = rabsg_pkg::GAP_CYC,
  parameter int unsigned CUR_W     = rabsg_pkg::CUR_W,
  parameter int unsigned VBUS_W    = rabsg_pkg::VBUS_W
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_align_start,
  input  wire logic [CUR_W-1:0]          i_phase_cur,
  input  wire logic [VBUS_W-1:0]         i_bus_volt,
  input  wire logic                      i_bus_volt_valid,
  input  wire logic [VBUS_W-1:0]         i_surge_thr,
  input  wire logic                      i_surge_clear,
  input  wire logic                      i_other_fault,
  input  wire rabsg_pkg::rabsg_gates_t   i_pwm_req,
  output rabsg_pkg::rabsg_gates_t        o_gates,
  output logic                           o_align_busy,
  output rabsg_pkg::rabsg_align_t        o_align,
  output logic                           o_critical_bus_surge
);

  // Elaboration check on parameters
  if (PULSE_CYC < 1 || GAP_CYC < 1 || PULSE_CYC > 65535 || GAP_CYC > 65535
      || CUR_W < 2 || VBUS_W < 2) begin : g_bad_param
    $error("rabsg_top: unsupported parameter value");
  end

  typedef enum logic [2:0] {
    RABSG_IDLE,
    RABSG_FWD,
    RABSG_GAP1,
    RABSG_OPP,
    RABSG_GAP2,
    RABSG_DONE
  } rabsg_state_t;

  rabsg_state_t            st_r;
  rabsg_state_t            st_nxt;
  logic [15:0]             cnt_r;
  logic [15:0]             cnt_nxt;
  logic [1:0]              ph_r;
  logic [1:0]              ph_nxt;
  logic [CUR_W-1:0]        pk_fwd_r;
  logic [CUR_W-1:0]        pk_fwd_nxt;
  logic [CUR_W-1:0]        pk_opp_r;
  logic [CUR_W-1:0]        pk_opp_nxt;
  logic [2:0]              pol_r;
  logic [2:0]              pol_nxt;
  rabsg_pkg::rabsg_align_t res_r;
  rabsg_pkg::rabsg_align_t res_nxt;
  logic                    surge_r;
  logic                    surge_nxt;
  rabsg_pkg::rabsg_gates_t sense_gates;
  rabsg_pkg::rabsg_gates_t req_gates;
  rabsg_pkg::rabsg_leg_t   req_leg [3];
  logic [5:0]              gate_bits;

  localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYC - 1);
  localparam logic [15:0] GAP_LAST   = 16'(GAP_CYC - 1);

  // Sector from three polarity bits, 60 degree resolution
  function automatic logic [2:0] pol_to_sector(input logic [2:0] p);
    logic [2:0] s;
    s = 3'h0;
    case (p)
      3'b001:  s = 3'h0;
      3'b011:  s = 3'h1;
      3'b010:  s = 3'h2;
      3'b110:  s = 3'h3;
      3'b100:  s = 3'h4;
      3'b101:  s = 3'h5;
      default: s = 3'h7;
    endcase
    return s;
  endfunction

  // Sensing sequencer next state
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    ph_nxt     = ph_r;
    pk_fwd_nxt = pk_fwd_r;
    pk_opp_nxt = pk_opp_r;
    pol_nxt    = pol_r;
    res_nxt    = res_r;
    case (st_r)
      RABSG_IDLE, RABSG_DONE: begin
        if (i_align_start && !surge_r && !i_other_fault) begin
          st_nxt       = RABSG_FWD;
          cnt_nxt      = 16'h0000;
          ph_nxt       = 2'h0;
          pk_fwd_nxt   = '0;
          pk_opp_nxt   = '0;
          pol_nxt      = 3'h0;
          res_nxt.valid = 1'b0;
        end
      end
      RABSG_FWD: begin
        if (i_phase_cur > pk_fwd_r) begin
          pk_fwd_nxt = i_phase_cur;
        end
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == PULSE_LAST) begin
          st_nxt  = RABSG_GAP1;
          cnt_nxt = 16'h0000;
        end
      end
      RABSG_GAP1: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == GAP_LAST) begin
          st_nxt  = RABSG_OPP;
          cnt_nxt = 16'h0000;
        end
      end
      RABSG_OPP: begin
        if (i_phase_cur > pk_opp_r) begin
          pk_opp_nxt = i_phase_cur;
        end
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == PULSE_LAST) begin
          st_nxt  = RABSG_GAP2;
          cnt_nxt = 16'h0000;
        end
      end
      RABSG_GAP2: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == GAP_LAST) begin
          cnt_nxt             = 16'h0000;
          pol_nxt[ph_r]       = (pk_fwd_r >= pk_opp_r);
          pk_fwd_nxt          = '0;
          pk_opp_nxt          = '0;
          if (ph_r == 2'h2) begin
            st_nxt           = RABSG_DONE;
            res_nxt.valid    = 1'b1;
            res_nxt.polarity = pol_nxt;
            res_nxt.sector   = pol_to_sector(pol_nxt);
          end else begin
            ph_nxt = ph_r + 2'h1;
            st_nxt = RABSG_FWD;
          end
        end
      end
      default: begin
        st_nxt = RABSG_IDLE;
      end
    endcase
    // Surge or other fault aborts sensing
    if (surge_r || i_other_fault) begin
      if (st_r != RABSG_IDLE && st_r != RABSG_DONE) begin
        st_nxt = RABSG_IDLE;
      end
    end
  end

  // Sensing sequencer registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r     <= RABSG_IDLE;
      cnt_r    <= 16'h0000;
      ph_r     <= 2'h0;
      pk_fwd_r <= '0;
      pk_opp_r <= '0;
      pol_r    <= 3'h0;
      res_r    <= '0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      ph_r     <= ph_nxt;
      pk_fwd_r <= pk_fwd_nxt;
      pk_opp_r <= pk_opp_nxt;
      pol_r    <= pol_nxt;
      res_r    <= res_nxt;
    end
  end

  // Surge flag: detection wins over clear, held until cleared
  always_comb begin
    surge_nxt = surge_r;
    if (i_surge_clear) begin
      surge_nxt = 1'b0;
    end
    if (i_bus_volt_valid && (i_bus_volt > i_surge_thr)) begin
      surge_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      surge_r <= 1'b0;
    end else begin
      surge_r <= surge_nxt;
    end
  end

  // Sensing patterns per leg
  always_comb begin
    sense_gates = '0;
    for (int k = 0; k < 3; k++) begin
      if (st_r == RABSG_FWD) begin
        gate_bits[2*k+1] = (k == int'(ph_r));
        gate_bits[2*k]   = (k != int'(ph_r));
      end else if (st_r == RABSG_OPP) begin
        gate_bits[2*k+1] = (k != int'(ph_r));
        gate_bits[2*k]   = (k == int'(ph_r));
      end else begin
        gate_bits[2*k+1] = 1'b0;
        gate_bits[2*k]   = 1'b0;
      end
    end
    sense_gates = rabsg_pkg::rabsg_gates_t'(gate_bits);
  end

  // Source select: other fault off, sensing, else normal PWM
  always_comb begin
    if (i_other_fault) begin
      req_gates = '0;
    end else if (st_r != RABSG_IDLE && st_r != RABSG_DONE) begin
      req_gates = sense_gates;
    end else begin
      req_gates = i_pwm_req;
    end
  end

  assign req_leg[0] = req_gates.u;
  assign req_leg[1] = req_gates.v;
  assign req_leg[2] = req_gates.w;

  // Output stage per leg; surge overrides all sources
  for (genvar g = 0; g < 3; g++) begin : g_leg
    rabsg_leg_guard u_guard (
      .i_ref_clk  (i_ref_clk),
      .i_rst      (i_rst),
      .i_zero_vec (surge_r),
      .i_req      (req_leg[g]),
      .o_hi       (o_gates[2*g+1]),
      .o_lo       (o_gates[2*g])
    );
  end

  assign o_align_busy         = (st_r != RABSG_IDLE) && (st_r != RABSG_DONE);
  assign o_align              = res_r;
  assign o_critical_bus_surge = surge_r;

endmodule
`default_nettype wire

// ==== rabsg_top_sva.sv ====
`default_nettype none
// Watches gate drive, surge flag and sensing order
module rabsg_top_sva (
  input wire logic                    i_ref_clk,
  input wire logic                    i_rst,
  input wire logic [11:0]             i_bus_volt,
  input wire logic                    i_bus_volt_valid,
  input wire logic [11:0]             i_surge_thr,
  input wire logic                    i_surge_clear,
  input wire logic                    i_other_fault,
  input wire rabsg_pkg::rabsg_gates_t o_gates,
  input wire logic                    o_align_busy,
  input wire rabsg_pkg::rabsg_align_t o_align,
  input wire logic                    o_critical_bus_surge
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] g;
  logic       hit;
  // Flat gate view and over-threshold sample
  assign g = o_gates;
  assign hit = i_bus_volt_valid && (i_bus_volt > i_surge_thr);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Steps of leg u sensing; lengths match the bench's 4-cycle pulse, 2-cycle gap
  sequence fwd_u; g == 6'h16 [*4]; endsequence
  sequence opp_u; g == 6'h29 [*4]; endsequence
  sequence gap;   g == 6'h00 [*2]; endsequence
  chk_no_shoot: assert property (((g >> 1) & g & 6'h15) == 6'h00)
    else $error("both switches of a leg on");
  chk_surge_flag: assert property (hit |=> o_critical_bus_surge)
    else $error("surge not flagged");
  chk_no_false: assert property (!o_critical_bus_surge && !hit |=> !o_critical_bus_surge)
    else $error("surge flagged without cause");
  chk_zero_vec: assert property (o_critical_bus_surge |=> g == 6'h15)
    else $error("zero vector missing");
  chk_surge_prio: assert property (o_critical_bus_surge && i_other_fault |=> g == 6'h15)
    else $error("fault beat zero vector");
  chk_surge_hold: assert property (o_critical_bus_surge && !i_surge_clear |=> o_critical_bus_surge)
    else $error("surge flag dropped early");
  chk_fwd_pulse: assert property ($rose(o_align_busy) |=> fwd_u ##1 gap)
    else $error("forward pulse wrong");
  chk_opp_pulse: assert property ($rose(o_align_busy) |=> ##6 opp_u ##1 gap)
    else $error("opposing pulse wrong");
  chk_valid_drop: assert property ($rose(o_align_busy) |-> !o_align.valid)
    else $error("stale result during sensing");
endmodule
bind rabsg_top rabsg_top_sva rabsg_top_sva_i (.i_ref_clk, .i_rst, .i_bus_volt,
  .i_bus_volt_valid, .i_surge_thr, .i_surge_clear, .i_other_fault, .o_gates,
  .o_align_busy, .o_align, .o_critical_bus_surge);
`default_nettype wire

// ==== rabsg_top_tb.sv ====
`default_nettype none
module rabsg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk, rst, start, vld, clr, flt, busy, surge;
  logic [11:0]             cur, volt, thr;
  logic [2:0]              pol;
  rabsg_pkg::rabsg_gates_t req, gates;
  rabsg_pkg::rabsg_align_t aln;
  int                      n_fail, check_count;
  rabsg_top #(.PULSE_CYC(4), .GAP_CYC(2)) rabsg_top_i (.i_ref_clk(clk), .i_rst(rst),
    .i_align_start(start), .i_phase_cur(cur), .i_bus_volt(volt), .i_bus_volt_valid(vld),
    .i_surge_thr(thr), .i_surge_clear(clr), .i_other_fault(flt), .i_pwm_req(req),
    .o_gates(gates), .o_align_busy(busy), .o_align(aln), .o_critical_bus_surge(surge));
  rabsg_drv_model rabsg_drv_model_i (.i_ref_clk(clk), .i_gates(gates), .i_pol(pol),
    .o_cur(cur));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One full sensing run against a given magnet polarity
  task automatic t_align(input logic [2:0] p, input logic [2:0] sec);
    int k;
    pol = p;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    chk(busy, 16'h0001);
    for (k = 0; k < 100 && busy === 1'b1; k++) cyc(1);
    if (k == 100) begin
      n_fail++;
      close_out();
    end
    chk(aln, {9'h000, 1'b1, p, sec});
    $display("align test %b done", p);
  endtask
  // Surge in mid-sensing aborts the run and forces the zero vector
  task automatic t_abort();
    pol = 3'b001;
    thr = 12'h800;
    volt = 12'h801;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(20);
    chk(busy, 16'h0001);
    vld = 1'b1;
    cyc(1);
    vld = 1'b0;
    chk(surge, 16'h0001);
    cyc(1);
    chk(busy, 16'h0000);
    chk(aln.valid, 16'h0000);
    chk(gates, 16'h0015);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk(surge, 16'h0000);
    $display("abort test done");
  endtask
  // Surge detect, priority, hold, clear, then fault and leg guard
  task automatic t_surge();
    thr = 12'h800;
    req = 6'h16;
    cyc(2);
    chk(gates, 16'h0016);
    volt = 12'h800;
    vld = 1'b1;
    cyc(1);
    vld = 1'b0;
    cyc(1);
    chk(surge, 16'h0000);
    volt = 12'h801;
    vld = 1'b1;
    cyc(1);
    vld = 1'b0;
    chk(surge, 16'h0001);
    flt = 1'b1;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    chk(gates, 16'h0015);
    chk(busy, 16'h0000);
    flt = 1'b0;
    cyc(3);
    chk(gates, 16'h0015);
    clr = 1'b1;
    vld = 1'b1;
    cyc(1);
    vld = 1'b0;
    chk(surge, 16'h0001);
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk(surge, 16'h0000);
    chk(gates, 16'h0016);
    req = 6'h3F;
    cyc(2);
    chk(gates, 16'h0000);
    req = 6'h16;
    flt = 1'b1;
    cyc(2);
    chk(gates, 16'h0000);
    flt = 1'b0;
    $display("surge test done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    start = 1'b0;
    vld = 1'b0;
    clr = 1'b0;
    flt = 1'b0;
    volt = 12'h000;
    thr = 12'hFFF;
    req = 6'h00;
    pol = 3'h0;
    n_fail = 0;
    check_count = 0;
    cyc(4);
    rst = 1'b0;
    chk({gates, surge, busy}, 16'h0000);
    t_align(3'b001, 3'h0);
    t_align(3'b011, 3'h1);
    t_align(3'b010, 3'h2);
    t_align(3'b110, 3'h3);
    t_align(3'b100, 3'h4);
    t_align(3'b101, 3'h5);
    t_align(3'b000, 3'h7);
    t_abort();
    t_surge();
    close_out();
  end
endmodule
`default_nettype wire
